// ==== inc/ptp_egress_pkg.sv ====
// Shared constants and types for the per-port timing egress timestamp block
package ptp_egress_pkg;

   // ****************************************************************
   // Register indices; byte address is four times the index
   // ****************************************************************
   localparam logic [7:0] IDX_TX_LATENCY = 8'h02;
   localparam logic [7:0] IDX_ASYMMETRY  = 8'h04;
   localparam logic [7:0] IDX_DREQ_HIGH  = 8'h08;
   localparam logic [7:0] IDX_DREQ_LOW   = 8'h0A;
   localparam logic [7:0] IDX_SYNC_HIGH  = 8'h0C;
   localparam logic [7:0] IDX_SYNC_LOW   = 8'h0E;
   localparam logic [7:0] IDX_DRESP_HIGH = 8'h10;
   localparam logic [7:0] IDX_DRESP_LOW  = 8'h12;
   localparam logic [7:0] IDX_FLAGS      = 8'h14;
   localparam logic [7:0] IDX_IRQ_ON     = 8'h16;

   localparam logic [7:0] ADDR_TX_LATENCY = 8'(IDX_TX_LATENCY * 4);
   localparam logic [7:0] ADDR_ASYMMETRY  = 8'(IDX_ASYMMETRY * 4);
   localparam logic [7:0] ADDR_DREQ_HIGH  = 8'(IDX_DREQ_HIGH * 4);
   localparam logic [7:0] ADDR_DREQ_LOW   = 8'(IDX_DREQ_LOW * 4);
   localparam logic [7:0] ADDR_SYNC_HIGH  = 8'(IDX_SYNC_HIGH * 4);
   localparam logic [7:0] ADDR_SYNC_LOW   = 8'(IDX_SYNC_LOW * 4);
   localparam logic [7:0] ADDR_DRESP_HIGH = 8'(IDX_DRESP_HIGH * 4);
   localparam logic [7:0] ADDR_DRESP_LOW  = 8'(IDX_DRESP_LOW * 4);
   localparam logic [7:0] ADDR_FLAGS      = 8'(IDX_FLAGS * 4);
   localparam logic [7:0] ADDR_IRQ_ON     = 8'(IDX_IRQ_ON * 4);

   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int unsigned ASYM_SIGN_BIT  = 15;
   localparam int unsigned FLAG_SYNC_BIT  = 15;
   localparam int unsigned FLAG_DREQ_BIT  = 14;
   localparam int unsigned FLAG_DRESP_BIT = 13;
   localparam int unsigned CORR_FRAC_BITS = 16;

   // ****************************************************************
   // Reset values
   // ****************************************************************
   localparam logic [15:0] TX_LATENCY_RST = 16'h002D;
   localparam logic [15:0] ASYMMETRY_RST  = 16'h0000;
   localparam logic [31:0] TIMESTAMP_RST  = 32'h0000_0000;
   localparam logic [2:0]  FLAGS_RST      = 3'h0;

   // ****************************************************************
   // Message classes and datapath carriers
   // ****************************************************************
   typedef enum logic [2:0] {
      MSG_OTHER,
      MSG_SYNC,
      MSG_DELAY_REQ,
      MSG_PDELAY_REQ,
      MSG_PDELAY_RESP
   } msg_kind_type;

   typedef struct packed {
      logic         valid;
      logic         egress;
      msg_kind_type kind;
      logic [63:0]  corr;
   } corr_req_type;

   typedef struct packed {
      logic         valid;
      msg_kind_type kind;
      logic [31:0]  time_ns;
   } egress_event_type;

endpackage

// ==== tb/testbench.sv ====
// Self-checking bench for the per-port egress timestamp block
`timescale 1ns/1ps
module testbench;
   import ptp_egress_pkg::*;

   // ****************************************************************
   // Signals
   // ****************************************************************
   typedef struct packed {
      logic        wr;
      logic [7:0]  addr;
      logic [31:0] wd;
      logic [31:0] exp;
      logic        err;
   } row_type;

   logic             clk;
   logic             rst_n;
   logic             psel;
   logic             penable;
   logic             pwrite;
   logic [7:0]       paddr;
   logic [31:0]      pwdata;
   logic [31:0]      prdata;
   logic             pready;
   logic             pslverr;
   corr_req_type     corr_in;
   corr_req_type     corr_out;
   egress_event_type egress_in;
   logic             irq;
   logic             ts_status;
   logic             ts_enable;
   int               n_mismatch;
   int               num_checks;
   int               cycles;
   logic [31:0]      rd;
   logic             err;
   logic [15:0]      asym_set [2] = '{16'h8005, 16'h7FFF};
   localparam logic [63:0] CORR_BASE = 64'h0000_0000_0003_0000;

   // Register table rows: reset values, access kinds, unmapped place
   localparam row_type ROWS [22] = '{
      '{1'b0, ADDR_TX_LATENCY, 32'h0, 32'h0000_002D, 1'b0}, '{1'b0, ADDR_ASYMMETRY, 32'h0, 32'h0, 1'b0},
      '{1'b0, ADDR_DREQ_HIGH, 32'h0, 32'h0, 1'b0}, '{1'b0, ADDR_DREQ_LOW, 32'h0, 32'h0, 1'b0},
      '{1'b0, ADDR_SYNC_HIGH, 32'h0, 32'h0, 1'b0}, '{1'b0, ADDR_SYNC_LOW, 32'h0, 32'h0, 1'b0},
      '{1'b0, ADDR_DRESP_HIGH, 32'h0, 32'h0, 1'b0}, '{1'b0, ADDR_DRESP_LOW, 32'h0, 32'h0, 1'b0},
      '{1'b0, ADDR_FLAGS, 32'h0, 32'h0, 1'b0}, '{1'b0, ADDR_IRQ_ON, 32'h0, 32'h0, 1'b0},
      '{1'b1, ADDR_TX_LATENCY, 32'h0000_0010, 32'h0, 1'b0}, '{1'b0, ADDR_TX_LATENCY, 32'h0, 32'h0000_0010, 1'b0},
      '{1'b1, ADDR_IRQ_ON, 32'hFFFF_FFFF, 32'h0, 1'b0}, '{1'b0, ADDR_IRQ_ON, 32'h0, 32'h0000_E000, 1'b0},
      '{1'b1, ADDR_DREQ_HIGH, 32'h0000_FFFF, 32'h0, 1'b0}, '{1'b0, ADDR_DREQ_HIGH, 32'h0, 32'h0, 1'b0},
      '{1'b1, ADDR_FLAGS, 32'h0000_FFFF, 32'h0, 1'b0}, '{1'b0, ADDR_FLAGS, 32'h0, 32'h0, 1'b0},
      '{1'b1, ADDR_ASYMMETRY, 32'hFFFF_8005, 32'h0, 1'b0}, '{1'b0, ADDR_ASYMMETRY, 32'h0, 32'h0000_8005, 1'b0},
      '{1'b0, 8'h04, 32'h0, 32'h0, 1'b1}, '{1'b1, 8'h04, 32'h0000_1234, 32'h0, 1'b1}};

   ptp_port_egress_timestamp dut (
      .i_clk            (clk),
      .i_rst_n          (rst_n),
      .i_psel           (psel),
      .i_penable        (penable),
      .i_pwrite         (pwrite),
      .i_paddr          (paddr),
      .i_pwdata         (pwdata),
      .o_prdata         (prdata),
      .o_pready         (pready),
      .o_pslverr        (pslverr),
      .i_corr           (corr_in),
      .o_corr           (corr_out),
      .i_egress         (egress_in),
      .o_irq            (irq),
      .o_port_ts_status (ts_status),
      .o_port_ts_enable (ts_enable)
   );

   // ****************************************************************
   // Clock, timeout and helpers
   // ****************************************************************
   // Free-running 50 MHz clock
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // Cuts a hang short
   always @(posedge clk) begin
      cycles = cycles + 1;
      if (cycles == 5000) begin
         n_mismatch++;
         $display("[ERR] run_length expected=done seen=hang");
         complete_run();
      end
   end

   task automatic check(input string name, input logic [71:0] seen, input logic [71:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected=%h seen=%h", name, exp, seen);
      end
   endtask

   task automatic complete_run();
      $display("Counts: %0d mismatches in %0d checks", n_mismatch, num_checks);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // One APB transfer, held until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
      @(posedge clk);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= addr;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rchk(input logic [7:0] addr, input logic [31:0] exp, input string name);
      apb(1'b0, addr, 32'h0);
      check(name, {40'h0, rd}, {40'h0, exp});
   endtask

   task automatic ev(input msg_kind_type k, input logic [31:0] t);
      @(posedge clk);
      egress_in <= '{1'b1, k, t};
   endtask

   task automatic ev_idle();
      @(posedge clk);
      egress_in <= '{1'b0, MSG_OTHER, 32'h0};
      repeat (4) @(posedge clk);
      #1;
   endtask

   // Signed asymmetry applied to the scaled correction field
   function automatic logic [63:0] exp_corr(input logic eg, input msg_kind_type k, input logic [15:0] asym);
      logic [63:0] adj;
      adj = {33'h0, asym[14:0], 16'h0000};
      if (asym[15]) adj = -adj;
      if (!eg && (k == MSG_SYNC || k == MSG_PDELAY_RESP)) return CORR_BASE + adj;
      if (eg && (k == MSG_DELAY_REQ || k == MSG_PDELAY_REQ)) return CORR_BASE - adj;
      return CORR_BASE;
   endfunction

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      n_mismatch = 0;
      num_checks = 0;
      cycles = 0;
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      corr_in = '0;
      egress_in = '0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      // Table rows
      foreach (ROWS[i]) begin
         apb(ROWS[i].wr, ROWS[i].addr, ROWS[i].wd);
         if (!ROWS[i].wr) check("read_data", {40'h0, rd}, {40'h0, ROWS[i].exp});
         check("slave_error", {71'h0, err}, {71'h0, ROWS[i].err});
      end
      // Enable indication follows the OR of the enables
      repeat (2) @(posedge clk);
      #1;
      check("port_enable", {71'h0, ts_enable}, 72'h1);
      apb(1'b1, ADDR_IRQ_ON, 32'h0000_0000);
      repeat (2) @(posedge clk);
      #1;
      check("port_enable", {71'h0, ts_enable}, 72'h0);
      apb(1'b1, ADDR_IRQ_ON, 32'h0000_4000);
      repeat (2) @(posedge clk);
      #1;
      check("port_enable", {71'h0, ts_enable}, 72'h1);
      // Correction path, every kind both directions, both signs
      for (int s = 0; s < 2; s++) begin
         apb(1'b1, ADDR_ASYMMETRY, {16'h0000, asym_set[s]});
         for (int e = 0; e < 2; e++) begin
            for (int k = 0; k < 5; k++) begin
               @(posedge clk);
               corr_in <= '{1'b1, e[0], msg_kind_type'(k), CORR_BASE};
               @(posedge clk);
               #1;
               check("corr_out", {3'h0, corr_out},
                     {3'h0, 1'b1, e[0], msg_kind_type'(k), exp_corr(e[0], msg_kind_type'(k), asym_set[s])});
            end
         end
      end
      @(posedge clk);
      corr_in <= '0;
      // Sync capture with wrap; flag set but masked
      ev(MSG_SYNC, 32'hFFFF_FFF8);
      ev_idle();
      check("port_status", {71'h0, ts_status}, 72'h1);
      check("irq_masked", {71'h0, irq}, 72'h0);
      rchk(ADDR_FLAGS, 32'h0000_8000, "flags_sync");
      rchk(ADDR_SYNC_HIGH, 32'h0000_0000, "sync_high");
      rchk(ADDR_SYNC_LOW, 32'h0000_0008, "sync_low");
      // Back-to-back requests, latest wins; other kinds ignored
      ev(MSG_DELAY_REQ, 32'h1234_5670);
      ev(MSG_PDELAY_REQ, 32'h1111_0000);
      ev(MSG_OTHER, 32'h2222_0000);
      ev_idle();
      check("irq_enabled", {71'h0, irq}, 72'h1);
      rchk(ADDR_DREQ_HIGH, 32'h0000_1111, "dreq_high");
      rchk(ADDR_DREQ_LOW, 32'h0000_0010, "dreq_low");
      ev(MSG_PDELAY_RESP, 32'hABCD_FFF0);
      ev_idle();
      rchk(ADDR_FLAGS, 32'h0000_E000, "flags_all");
      rchk(ADDR_DRESP_HIGH, 32'h0000_ABCE, "dresp_high");
      rchk(ADDR_DRESP_LOW, 32'h0000_0000, "dresp_low");
      // Write-one clears, one bit at a time
      apb(1'b1, ADDR_FLAGS, 32'h0000_4000);
      repeat (2) @(posedge clk);
      #1;
      check("irq_cleared", {71'h0, irq}, 72'h0);
      check("port_status", {71'h0, ts_status}, 72'h1);
      rchk(ADDR_FLAGS, 32'h0000_A000, "flags_w1c");
      apb(1'b1, ADDR_FLAGS, 32'h0000_8000);
      rchk(ADDR_FLAGS, 32'h0000_2000, "flags_w1c");
      apb(1'b1, ADDR_FLAGS, 32'h0000_2000);
      rchk(ADDR_FLAGS, 32'h0000_0000, "flags_w1c");
      repeat (2) @(posedge clk);
      #1;
      check("port_status", {71'h0, ts_status}, 72'h0);
      // Event and clear in the same cycle: the event wins
      fork
         apb(1'b1, ADDR_FLAGS, 32'h0000_4000);
         begin
            repeat (2) @(posedge clk);
            egress_in <= '{1'b1, MSG_DELAY_REQ, 32'h0000_0200};
            @(posedge clk);
            egress_in <= '{1'b0, MSG_OTHER, 32'h0};
         end
      join
      rchk(ADDR_FLAGS, 32'h0000_4000, "flags_set_wins");
      // Reset in mid-run with a pending interrupt
      ev(MSG_DELAY_REQ, 32'h0000_0100);
      ev_idle();
      check("irq_enabled", {71'h0, irq}, 72'h1);
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      check("reset_outputs", {69'h0, irq, ts_status, ts_enable}, 72'h0);
      @(posedge clk);
      rst_n <= 1'b1;
      rchk(ADDR_FLAGS, 32'h0000_0000, "flags_reset");
      rchk(ADDR_TX_LATENCY, 32'h0000_002D, "latency_reset");
      rchk(ADDR_ASYMMETRY, 32'h0000_0000, "asym_reset");
      rchk(ADDR_DREQ_LOW, 32'h0000_0000, "dreq_reset");
      complete_run();
   end
endmodule

// ==== verilog/ptp_port_egress_timestamp.sv ====
// Per-port timing helper: asymmetry correction, egress timestamps, ready flags
//
// Function
// - Asymmetry bit 15 is sign, resets zero
// - Add signed asymmetry on ingress Sync, Pdelay_Resp
// - Subtract signed asymmetry on egress delay requests
// - Capture delay request egress time, two words
// - Capture Sync egress time, two read-only words
// - Capture Pdelay_Resp egress time, two words
// - Bit 15 flags Sync time, write-one clears
// - Bit 14 flags request time, write-one clears
// - Bit 13 flags response time, write-one clears
// - Port status is OR of flags
// - Enable bits 15:13, OR gives port enable
// - Writable transmit latency, default 45, offsets timestamps
`timescale 1ns/1ps
module ptp_port_egress_timestamp (
   input  wire logic                               i_clk,
   input  wire logic                               i_rst_n,
   input  wire logic                               i_psel,
   input  wire logic                               i_penable,
   input  wire logic                               i_pwrite,
   input  wire logic [7:0]                         i_paddr,
   input  wire logic [31:0]                        i_pwdata,
   output logic      [31:0]                        o_prdata,
   output logic                                    o_pready,
   output logic                                    o_pslverr,
   input  wire ptp_egress_pkg::corr_req_type       i_corr,
   output ptp_egress_pkg::corr_req_type            o_corr,
   input  wire ptp_egress_pkg::egress_event_type   i_egress,
   output logic                                    o_irq,
   output logic                                    o_port_ts_status,
   output logic                                    o_port_ts_enable
);
   import ptp_egress_pkg::*;

   // ****************************************************************
   // Declarations
   // ****************************************************************
   logic [15:0] tx_latency_q;
   logic [15:0] asymmetry_q;
   logic [2:0]  flags_q;
   logic [2:0]  irq_on_q;
   logic        access;
   logic        wr_en;
   logic        rd_hit;
   logic [31:0] rd_data;
   logic [31:0] egress_adj;
   logic        take_sync;
   logic        take_dreq;
   logic        take_dresp;
   logic [31:0] sync_time;
   logic [31:0] dreq_time;
   logic [31:0] dresp_time;
   logic        sync_ready;
   logic        dreq_ready;
   logic        dresp_ready;
   logic [2:0]  flag_set;
   logic [2:0]  flag_clr;
   logic [63:0] asym_scaled;
   logic        corr_adds;
   logic        corr_subs;
   logic        asymmetry_sign;
   logic [14:0] asymmetry_magnitude;

   // ****************************************************************
   // Bus slave
   // ****************************************************************

   // Access phase seen; answer comes one cycle later
   assign access = i_psel && i_penable;
   assign wr_en  = access && o_pready && i_pwrite;

   // Ready for one cycle per transfer, two-cycle access phase
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_pready <= 1'b0;
      end else begin
         o_pready <= access && !o_pready;
      end
   end

   // Address decode for reads and for the error answer
   always_comb begin
      rd_hit  = 1'b1;
      rd_data = 32'h0000_0000;
      case (i_paddr)
         ADDR_TX_LATENCY: rd_data[15:0] = tx_latency_q;
         ADDR_ASYMMETRY:  rd_data[15:0] = asymmetry_q;
         ADDR_DREQ_HIGH:  rd_data[15:0] = dreq_time[31:16];
         ADDR_DREQ_LOW:   rd_data[15:0] = dreq_time[15:0];
         ADDR_SYNC_HIGH:  rd_data[15:0] = sync_time[31:16];
         ADDR_SYNC_LOW:   rd_data[15:0] = sync_time[15:0];
         ADDR_DRESP_HIGH: rd_data[15:0] = dresp_time[31:16];
         ADDR_DRESP_LOW:  rd_data[15:0] = dresp_time[15:0];
         ADDR_FLAGS:      rd_data[15:13] = flags_q;
         ADDR_IRQ_ON:     rd_data[15:13] = irq_on_q;
         default:         rd_hit = 1'b0;
      endcase
   end

   // Read data and error latched in the first access cycle
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_prdata  <= 32'h0000_0000;
         o_pslverr <= 1'b0;
      end else if (access && !o_pready) begin
         o_prdata  <= i_pwrite ? 32'h0000_0000 : rd_data;
         o_pslverr <= !rd_hit;
      end else begin
         o_pslverr <= 1'b0;
      end
   end

   // ****************************************************************
   // Configuration registers
   // ****************************************************************

   // Transmit latency, software writable
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         tx_latency_q <= TX_LATENCY_RST;
      end else if (wr_en && i_paddr == ADDR_TX_LATENCY) begin
         tx_latency_q <= i_pwdata[15:0];
      end
   end

   // Signed asymmetry: sign in bit 15, magnitude below
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         asymmetry_q <= ASYMMETRY_RST;
      end else if (wr_en && i_paddr == ADDR_ASYMMETRY) begin
         asymmetry_q <= i_pwdata[15:0];
      end
   end

   // Per-class interrupt enables
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         irq_on_q <= FLAGS_RST;
      end else if (wr_en && i_paddr == ADDR_IRQ_ON) begin
         irq_on_q <= i_pwdata[15:13];
      end
   end

   // ****************************************************************
   // Correction field datapath
   // ****************************************************************

   // Magnitude in whole ns, shifted to the scaled field
   assign asymmetry_sign      = asymmetry_q[ASYM_SIGN_BIT];
   assign asymmetry_magnitude = asymmetry_q[14:0];
   assign asym_scaled = {33'h0_0000_0000, asymmetry_magnitude, 16'h0000};

   // Ingress adds the signed value, egress requests subtract it
   always_comb begin
      corr_adds = 1'b0;
      corr_subs = 1'b0;
      if (!i_corr.egress && (i_corr.kind == MSG_SYNC || i_corr.kind == MSG_PDELAY_RESP)) begin
         corr_adds = !asymmetry_sign;
         corr_subs = asymmetry_sign;
      end else if (i_corr.egress && (i_corr.kind == MSG_DELAY_REQ || i_corr.kind == MSG_PDELAY_REQ)) begin
         corr_adds = asymmetry_sign;
         corr_subs = !asymmetry_sign;
      end
   end

   // Registered corrected message, other classes pass unchanged
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_corr <= '0;
      end else begin
         o_corr <= i_corr;
         if (corr_adds) begin
            o_corr.corr <= i_corr.corr + asym_scaled;
         end else if (corr_subs) begin
            o_corr.corr <= i_corr.corr - asym_scaled;
         end
      end
   end

   // ****************************************************************
   // Egress timestamp capture
   // ****************************************************************

   // Raw egress point moved to the wire by the latency
   assign egress_adj = i_egress.time_ns + {16'h0000, tx_latency_q};
   assign take_sync  = i_egress.valid && i_egress.kind == MSG_SYNC;
   assign take_dreq  = i_egress.valid
                    && (i_egress.kind == MSG_DELAY_REQ || i_egress.kind == MSG_PDELAY_REQ);
   assign take_dresp = i_egress.valid && i_egress.kind == MSG_PDELAY_RESP;

   // Sync holding register
   ts_capture #(.W(32)) u_sync (
      .i_clk   (i_clk),
      .i_rst_n (i_rst_n),
      .i_take  (take_sync),
      .i_time  (egress_adj),
      .o_time  (sync_time),
      .o_ready (sync_ready)
   );

   // Delay request holding register
   ts_capture #(.W(32)) u_dreq (
      .i_clk   (i_clk),
      .i_rst_n (i_rst_n),
      .i_take  (take_dreq),
      .i_time  (egress_adj),
      .o_time  (dreq_time),
      .o_ready (dreq_ready)
   );

   // Delay response holding register
   ts_capture #(.W(32)) u_dresp (
      .i_clk   (i_clk),
      .i_rst_n (i_rst_n),
      .i_take  (take_dresp),
      .i_time  (egress_adj),
      .o_time  (dresp_time),
      .o_ready (dresp_ready)
   );

   // ****************************************************************
   // Ready flags and interrupt
   // ****************************************************************

   // Flags index 2..0 map to bits 15..13
   assign flag_set = {sync_ready, dreq_ready, dresp_ready};
   assign flag_clr = (wr_en && i_paddr == ADDR_FLAGS) ? i_pwdata[15:13] : 3'h0;

   // Sticky flags, a new event wins over a clear
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         flags_q <= FLAGS_RST;
      end else begin
         flags_q <= (flags_q & ~flag_clr) | flag_set;
      end
   end

   // Port summaries and gated interrupt
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_port_ts_status <= 1'b0;
         o_port_ts_enable <= 1'b0;
         o_irq            <= 1'b0;
      end else begin
         o_port_ts_status <= |flags_q;
         o_port_ts_enable <= |irq_on_q;
         o_irq            <= |(flags_q & irq_on_q);
      end
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   a_ingress_add : assert property (
      i_corr.valid && !i_corr.egress && i_corr.kind == MSG_SYNC && !asymmetry_sign
      |=> o_corr.corr == $past(i_corr.corr) + $past(asym_scaled))
      else $error("ingress sync correction not increased");

   a_sign_flips_add : assert property (
      i_corr.valid && !i_corr.egress && i_corr.kind == MSG_PDELAY_RESP && asymmetry_sign
      |=> o_corr.corr == $past(i_corr.corr) - $past(asym_scaled))
      else $error("negative asymmetry not subtracted");

   a_egress_subtract : assert property (
      i_corr.valid && i_corr.egress && i_corr.kind == MSG_DELAY_REQ && !asymmetry_sign
      |=> o_corr.corr == $past(i_corr.corr) - $past(asym_scaled))
      else $error("egress request correction not decreased");

   a_dreq_capture : assert property (
      take_dreq |=> dreq_time == $past(i_egress.time_ns) + {16'h0000, $past(tx_latency_q)})
      else $error("request timestamp not captured with latency");

   a_sync_flag_set : assert property (
      take_sync |-> ##2 flags_q[2])
      else $error("sync flag not set two cycles after egress");

   a_flag_sticky : assert property (
      flags_q[2] && !flag_clr[2] |=> flags_q[2])
      else $error("sync flag dropped without clear");

   a_dreq_flag_set : assert property (
      take_dreq |-> ##2 flags_q[1])
      else $error("request flag not set");

   a_dresp_flag_set : assert property (
      take_dresp ##1 !take_dresp |-> ##1 flags_q[0] && dresp_time == $past(dresp_time))
      else $error("response flag not set after capture");

   a_status_or : assert property (
      $changed(flags_q) |=> o_port_ts_status == |$past(flags_q))
      else $error("port status not OR of flags");

   a_enable_or : assert property (
      wr_en && i_paddr == ADDR_IRQ_ON |-> ##2 o_port_ts_enable == |$past(i_pwdata[15:13], 2))
      else $error("port enable not OR of enables");

   a_latency_write : assert property (
      wr_en && i_paddr == ADDR_TX_LATENCY |=> tx_latency_q == $past(i_pwdata[15:0]))
      else $error("latency write lost");

   a_words_first : assert property (
      take_sync && !flags_q[2] && !sync_ready |=> !flags_q[2])
      else $error("sync flag set with the words");

endmodule

// ==== verilog/ts_capture.sv ====
// One timestamp holding register with a delayed ready pulse
`timescale 1ns/1ps
module ts_capture #(
   parameter int unsigned W = 32
) (
   input  wire logic         i_clk,
   input  wire logic         i_rst_n,
   input  wire logic         i_take,
   input  wire logic [W-1:0] i_time,
   output logic      [W-1:0] o_time,
   output logic              o_ready
);

   // ****************************************************************
   // Capture and ready
   // ****************************************************************

   // Both words load together at the capture edge
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_time <= '0;
      end else if (i_take) begin
         o_time <= i_time;
      end
   end

   // Ready rises at the same edge as the words load, one cycle after the take
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_ready <= 1'b0;
      end else begin
         o_ready <= i_take;
      end
   end

   a_ready_after_load : assert property (@(posedge i_clk) disable iff (!i_rst_n)
      i_take |=> o_ready && o_time == $past(i_time)) else $error("ready without loaded time");

endmodule
